// ==== logic/stm_pkg.sv ====
// How it works
// - Mode field 00 picks compare output; other codes pick capture, PWM/pulse, timer.
// - Compare, clear select low: clear on P match or overflow; both flags set.
// - Compare, clear select high: clear on A match; only the A flag set.
// - Compare A value zero, clear select high: counter wraps at 3FF, no A flag.
// - Compare mode pin changes on A match, as pin function selects.
// - Counter on rising loads pin with initial level; function 00 keeps pin.
// - Mode 11 acts as compare mode with same flags but leaves pin undriven.
// - Mode 10 with function 10 gives fixed-frequency variable-duty PWM.
// - PWM swap bit picks period register; clear select ignored in PWM.
// - PWM sets A flag on every A match, P flag on every P match.
// - PWM: initial level gives active level, invert flips; 00/01 force levels.
// - Swap zero: period P times 128 or 1024 for zero; duty is A.
// - Duty at or above period holds the PWM output fully active.
// - Swap one: period is A; duty P times 128 or 1024 for zero.
// - Mode 10 with function 11 gives one output pulse per trigger.
// - Pulse mode: external pin edge or software sets counter on, pulse starts.
// - Pulse ends on software clear or A match; A match clears on, sets flag.
// - Pulse mode clears counter only on counter on rising; P, swap ignored.
// - Mode 01 latches counter into compare A on selected edge, sets flag.
// - Capture counter free-runs; P match clears counter and sets P flag.
// - Capture with function 11 captures nothing; counter keeps running.
// - Compare pin function: 00 keep, 01 low, 10 high, 11 toggle.
// - Counter on rising zeroes the counter; falling keeps its value.
// - Compare P is 3 bits against counter bits 9 to 7; zero means overflow.
// - Capture edge: 00 rising, 01 falling, 10 both, 11 disabled.
`default_nettype none
package stm_pkg;
	// ==================================================
	// Register map
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  ADDR_CTRL0   = 8'h00;
	localparam logic [7:0]  ADDR_CTRL1   = 8'h04;
	localparam logic [7:0]  ADDR_COUNT   = 8'h08;
	localparam logic [7:0]  ADDR_COMPARE_A_VALUE_LO = 8'h0c;
	localparam logic [7:0]  ADDR_COMPARE_A_VALUE_HI = 8'h10;
	localparam logic [7:0]  ADDR_FLAGS   = 8'h14;
	// ==================================================
	// Field positions
	localparam int          ON_BIT       = 3;
	localparam int          CKS_LSB      = 4;
	localparam int          MODE_LSB     = 6;
	localparam int          PFS_LSB      = 4;
	localparam int          OC_BIT       = 3;
	localparam int          POL_BIT      = 2;
	localparam int          DPX_BIT      = 1;
	localparam int          CCS_BIT      = 0;
	localparam int          FLAG_P_BIT   = 1;
	// ==================================================
	// Reset values and counts
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [9:0]  COMPARE_A_VALUE_RST     = 10'h000;
	localparam logic [10:0] PERIOD_FULL  = 11'h400;
	// ==================================================
	// Codes
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_PWM     = 2'b10,
		MODE_TIMER   = 2'b11
	} stm_mode_type;
	localparam logic [1:0]  PFS_LOW      = 2'b01;
	localparam logic [1:0]  PFS_HIGH     = 2'b10;
	localparam logic [1:0]  PFS_TOGGLE   = 2'b11;
	localparam logic [1:0]  PFS_OFF      = 2'b00;
	localparam logic [1:0]  PFS_ON       = 2'b01;
	localparam logic [1:0]  PFS_SINGLE   = 2'b11;
	localparam logic [1:0]  CAP_RISE     = 2'b00;
	localparam logic [1:0]  CAP_FALL     = 2'b01;
	localparam logic [1:0]  CAP_BOTH     = 2'b10;
	localparam logic [2:0]  CKS_DIV4     = 3'b000;
	localparam logic [2:0]  CKS_DIV1     = 3'b001;
	localparam logic [2:0]  CKS_DIV16    = 3'b010;
	localparam logic [2:0]  CKS_DIV64    = 3'b011;
	localparam logic [2:0]  CKS_SUB0     = 3'b100;
	localparam logic [2:0]  CKS_SUB1     = 3'b101;
	localparam logic [2:0]  CKS_EXT_RISE = 3'b110;
	localparam logic [2:0]  CKS_EXT_FALL = 3'b111;
endpackage : stm_pkg
`default_nettype wire

// ==== logic/stm_edge.sv ====
`timescale 1ns/10ps
`default_nettype none
module stm_edge (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Pin and edges
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);
	logic prev;

	// Previous pin level
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev <= 1'b0;
		end else begin
			prev <= pin_i;
		end
	end

	// Edge pulses
	assign rise_o = pin_i & ~prev;
	assign fall_o = ~pin_i & prev;
endmodule : stm_edge
`default_nettype wire

// ==== logic/stm_prescaler.sv ====
`timescale 1ns/10ps
`default_nettype none
module stm_prescaler (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Source select and external edges
	input  wire logic [2:0] sel_i,
	input  wire logic       ext_rise_i,
	input  wire logic       ext_fall_i,
	// Timer tick
	output logic            tick_o
);
	logic [7:0] pre;

	// True when the low n bits are all ones
	function automatic logic low_ones(input logic [7:0] v, input int n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < n; i++) begin
			r = r & v[i];
		end
		return r;
	endfunction : low_ones

	// Free-running divider
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre <= 8'h00;
		end else begin
			pre <= pre + 8'h01;
		end
	end

	// Tick selection
	always_comb begin
		unique case (sel_i)
			stm_pkg::CKS_DIV4:     tick_o = low_ones(pre, 2);
			stm_pkg::CKS_DIV1:     tick_o = 1'b1;
			stm_pkg::CKS_DIV16:    tick_o = low_ones(pre, 4);
			stm_pkg::CKS_DIV64:    tick_o = low_ones(pre, 6);
			stm_pkg::CKS_SUB0,
			stm_pkg::CKS_SUB1:     tick_o = low_ones(pre, 8);
			stm_pkg::CKS_EXT_RISE: tick_o = ext_rise_i;
			stm_pkg::CKS_EXT_FALL: tick_o = ext_fall_i;
		endcase
	end
endmodule : stm_prescaler
`default_nettype wire

// ==== logic/stm_timer.sv ====
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module stm_timer (
	// Clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_N_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Timer pins
	input  wire logic        EXT_CLK_I,
	input  wire logic        CAPTURE_I,
	output logic             PIN_O,
	output logic             PIN_OE_N_O
);
	// ==================================================
	// Declarations
	logic [2:0]           clk_sel;
	logic                 counter_on;
	logic                 on_d;
	logic [2:0]           compare_p_value;
	stm_pkg::stm_mode_type mode;
	logic [1:0]           pfs;
	logic                 oc;
	logic                 pol;
	logic                 dpx;
	logic                 ccs;
	logic [9:0]           compare_a_value;
	logic [9:0]           count;
	logic                 flag_a;
	logic                 flag_p;
	logic                 cmp_lvl;
	logic                 ext_rise;
	logic                 ext_fall;
	logic                 cap_rise;
	logic                 cap_fall;
	logic                 tick;
	logic                 on_rise;
	logic                 run_tick;
	logic [10:0]          cnt_inc;
	logic [10:0]          compare_p_value_len;
	logic [10:0]          compare_a_value_len;
	logic [10:0]          duty;
	logic [10:0]          period;
	logic                 hit_a;
	logic                 hit_p;
	logic                 clr;
	logic                 set_a;
	logic                 set_p;
	logic                 single;
	logic                 trig;
	logic                 cap_evt;
	logic                 pwm_on;
	logic                 acc;
	logic                 wr;
	logic                 rd_req;
	logic                 rd_hit;
	logic [31:0]          rd_word;

	// ==================================================
	// Edge detectors and clock source
	stm_edge u_ext_edge (
		.clk_i   (CORE_CLK_I),
		.rst_n_i (RST_N_I),
		.pin_i   (EXT_CLK_I),
		.rise_o  (ext_rise),
		.fall_o  (ext_fall)
	);

	stm_edge u_cap_edge (
		.clk_i   (CORE_CLK_I),
		.rst_n_i (RST_N_I),
		.pin_i   (CAPTURE_I),
		.rise_o  (cap_rise),
		.fall_o  (cap_fall)
	);

	stm_prescaler u_presc (
		.clk_i      (CORE_CLK_I),
		.rst_n_i    (RST_N_I),
		.sel_i      (clk_sel),
		.ext_rise_i (ext_rise),
		.ext_fall_i (ext_fall),
		.tick_o     (tick)
	);

	// ==================================================
	// Bus decode
	// Known register address
	function automatic logic addr_ok(input logic [7:0] a);
		return (a == stm_pkg::ADDR_CTRL0) || (a == stm_pkg::ADDR_CTRL1) ||
			(a == stm_pkg::ADDR_COUNT) || (a == stm_pkg::ADDR_COMPARE_A_VALUE_LO) ||
			(a == stm_pkg::ADDR_COMPARE_A_VALUE_HI) || (a == stm_pkg::ADDR_FLAGS);
	endfunction : addr_ok

	// Access completes when our ready is up
	assign acc    = PSEL_I & PENABLE_I & PREADY_O;
	assign wr     = acc & PWRITE_I & addr_ok(PADDR_I);
	assign rd_req = PSEL_I & PENABLE_I & ~PREADY_O;

	// ==================================================
	// Counter arithmetic
	assign on_rise  = counter_on & ~on_d;
	assign run_tick = counter_on & tick;
	assign cnt_inc  = {1'b0, count} + 11'd1;
	// P length in steps of 128, zero meaning full span
	assign compare_p_value_len = (compare_p_value == 3'b000) ? stm_pkg::PERIOD_FULL : {1'b0, compare_p_value, 7'h00};
	assign compare_a_value_len = (compare_a_value == 10'h000) ? stm_pkg::PERIOD_FULL : {1'b0, compare_a_value};
	// A match never fires for a zero compare value
	assign hit_a    = run_tick & (compare_a_value != 10'h000) & (cnt_inc == {1'b0, compare_a_value});
	// P match, overflow when the P value is zero
	assign hit_p    = run_tick & (cnt_inc == compare_p_value_len);
	assign single   = (mode == stm_pkg::MODE_PWM) && (pfs == stm_pkg::PFS_SINGLE);
	assign trig     = (clk_sel == stm_pkg::CKS_EXT_FALL) ? ext_fall : ext_rise;

	// ==================================================
	// Mode decode: counter clear and flag sources
	always_comb begin
		clr   = 1'b0;
		set_a = 1'b0;
		set_p = 1'b0;
		unique case (mode)
			stm_pkg::MODE_COMPARE,
			stm_pkg::MODE_TIMER: begin
				set_a = hit_a;
				if (ccs) begin
					clr = hit_a;
				end else begin
					clr   = hit_p;
					set_p = hit_p;
				end
			end
			stm_pkg::MODE_CAPTURE: begin
				clr   = hit_p;
				set_a = cap_evt;
				set_p = hit_p;
			end
			stm_pkg::MODE_PWM: begin
				set_a = hit_a;
				if (!single) begin
					clr   = dpx ? hit_a : hit_p;
					set_p = hit_p;
				end
			end
		endcase
	end

	// Capture edge selection
	always_comb begin
		cap_evt = 1'b0;
		if (counter_on && (mode == stm_pkg::MODE_CAPTURE)) begin
			unique case (pfs)
				stm_pkg::CAP_RISE: cap_evt = cap_rise;
				stm_pkg::CAP_FALL: cap_evt = cap_fall;
				stm_pkg::CAP_BOTH: cap_evt = cap_rise | cap_fall;
				stm_pkg::PFS_SINGLE: cap_evt = 1'b0;
			endcase
		end
	end

	// PWM duty and period
	always_comb begin
		if (dpx) begin
			period = compare_a_value_len;
			duty   = compare_p_value_len;
		end else begin
			period = compare_p_value_len;
			duty   = {1'b0, compare_a_value};
		end
		pwm_on = (duty >= period) || ({1'b0, count} < duty);
	end

	// ==================================================
	// Control registers
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			clk_sel <= stm_pkg::CTRL_RST[6:4];
			compare_p_value    <= stm_pkg::CTRL_RST[2:0];
			mode    <= stm_pkg::MODE_COMPARE;
			pfs     <= stm_pkg::CTRL_RST[5:4];
			oc      <= 1'b0;
			pol     <= 1'b0;
			dpx     <= 1'b0;
			ccs     <= 1'b0;
		end else if (wr && (PADDR_I == stm_pkg::ADDR_CTRL0)) begin
			clk_sel <= PWDATA_I[stm_pkg::CKS_LSB +: 3];
			compare_p_value    <= PWDATA_I[2:0];
		end else if (wr && (PADDR_I == stm_pkg::ADDR_CTRL1)) begin
			mode    <= stm_pkg::stm_mode_type'(PWDATA_I[stm_pkg::MODE_LSB +: 2]);
			pfs     <= PWDATA_I[stm_pkg::PFS_LSB +: 2];
			oc      <= PWDATA_I[stm_pkg::OC_BIT];
			pol     <= PWDATA_I[stm_pkg::POL_BIT];
			dpx     <= PWDATA_I[stm_pkg::DPX_BIT];
			ccs     <= PWDATA_I[stm_pkg::CCS_BIT];
		end
	end

	// Counter on bit: software, pulse trigger and pulse end
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			counter_on <= 1'b0;
		end else if (wr && (PADDR_I == stm_pkg::ADDR_CTRL0)) begin
			counter_on <= PWDATA_I[stm_pkg::ON_BIT];
		end else if (single && trig && !counter_on) begin
			counter_on <= 1'b1;
		end else if (single && hit_a) begin
			counter_on <= 1'b0;
		end
	end

	// Delayed on bit for edge detection
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			on_d <= 1'b0;
		end else begin
			on_d <= counter_on;
		end
	end

	// Compare A value: software write or capture
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			compare_a_value <= stm_pkg::COMPARE_A_VALUE_RST;
		end else if (cap_evt) begin
			compare_a_value <= count;
		end else if (wr && (PADDR_I == stm_pkg::ADDR_COMPARE_A_VALUE_LO)) begin
			compare_a_value[7:0] <= PWDATA_I[7:0];
		end else if (wr && (PADDR_I == stm_pkg::ADDR_COMPARE_A_VALUE_HI)) begin
			compare_a_value[9:8] <= PWDATA_I[1:0];
		end
	end

	// ==================================================
	// Counter
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			count <= 10'h000;
		end else if (on_rise) begin
			count <= 10'h000;
		end else if (run_tick) begin
			if (clr) begin
				count <= 10'h000;
			end else begin
				count <= cnt_inc[9:0];
			end
		end
	end

	// ==================================================
	// Flags, write one to clear, set wins
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			flag_a <= 1'b0;
			flag_p <= 1'b0;
		end else begin
			if (set_a) begin
				flag_a <= 1'b1;
			end else if (wr && (PADDR_I == stm_pkg::ADDR_FLAGS) && PWDATA_I[0]) begin
				flag_a <= 1'b0;
			end
			if (set_p) begin
				flag_p <= 1'b1;
			end else if (wr && (PADDR_I == stm_pkg::ADDR_FLAGS) && PWDATA_I[stm_pkg::FLAG_P_BIT]) begin
				flag_p <= 1'b0;
			end
		end
	end

	// ==================================================
	// Compare output level
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cmp_lvl <= 1'b0;
		end else if (on_rise) begin
			cmp_lvl <= oc;
		end else if (hit_a && (mode == stm_pkg::MODE_COMPARE)) begin
			unique case (pfs)
				stm_pkg::PFS_LOW:    cmp_lvl <= 1'b0;
				stm_pkg::PFS_HIGH:   cmp_lvl <= 1'b1;
				stm_pkg::PFS_TOGGLE: cmp_lvl <= ~cmp_lvl;
				stm_pkg::PFS_OFF:    cmp_lvl <= cmp_lvl;
			endcase
		end
	end

	// Output pin and its enable
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PIN_O      <= 1'b0;
			PIN_OE_N_O <= 1'b1;
		end else begin
			unique case (mode)
				stm_pkg::MODE_COMPARE: begin
					PIN_O      <= cmp_lvl ^ pol;
					PIN_OE_N_O <= 1'b0;
				end
				stm_pkg::MODE_PWM: begin
					PIN_OE_N_O <= 1'b0;
					if (single) begin
						PIN_O <= (counter_on ? oc : ~oc) ^ pol;
					end else if (pfs == stm_pkg::PFS_OFF) begin
						PIN_O <= ~oc ^ pol;
					end else if (pfs == stm_pkg::PFS_ON) begin
						PIN_O <= oc ^ pol;
					end else begin
						PIN_O <= (pwm_on ? oc : ~oc) ^ pol;
					end
				end
				stm_pkg::MODE_CAPTURE,
				stm_pkg::MODE_TIMER: begin
					PIN_OE_N_O <= 1'b1;
				end
			endcase
		end
	end

	// ==================================================
	// Read mux
	always_comb begin
		rd_hit  = addr_ok(PADDR_I);
		rd_word = 32'h0000_0000;
		unique case (PADDR_I)
			stm_pkg::ADDR_CTRL0:   rd_word = {25'h0, clk_sel, counter_on, compare_p_value};
			stm_pkg::ADDR_CTRL1:   rd_word = {24'h0, mode, pfs, oc, pol, dpx, ccs};
			stm_pkg::ADDR_COUNT:   rd_word = {22'h0, count};
			stm_pkg::ADDR_COMPARE_A_VALUE_LO: rd_word = {24'h0, compare_a_value[7:0]};
			stm_pkg::ADDR_COMPARE_A_VALUE_HI: rd_word = {30'h0, compare_a_value[9:8]};
			stm_pkg::ADDR_FLAGS:   rd_word = {30'h0, flag_p, flag_a};
			default:               rd_word = 32'h0000_0000;
		endcase
	end

	// Ready, error and read data, one wait state
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
		end else begin
			PREADY_O  <= rd_req;
			PSLVERR_O <= rd_req & ~rd_hit;
			if (rd_req && !PWRITE_I) begin
				PRDATA_O <= rd_word;
			end
		end
	end
endmodule : stm_timer
`default_nettype wire

// ==== verif/stm_timer_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module stm_timer_asserts (
	// Clock and reset
	input wire logic        CORE_CLK_I,
	input wire logic        RST_N_I,
	// Register bus
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	// Timer pins
	input wire logic        EXT_CLK_I,
	input wire logic        CAPTURE_I,
	input wire logic        PIN_O,
	input wire logic        PIN_OE_N_O
);
	// ==================================================
	// Shadow of control writes
	logic       done;
	logic [7:0] ctrl1;
	logic       on;
	logic [2:0] quiet;
	assign done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
	// Control shadow, and a settle counter that restarts on each control write
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl1 <= 8'h00;
			on    <= 1'b0;
			quiet <= 3'h0;
		end else begin
			if (done && PADDR_I == stm_pkg::ADDR_CTRL1) begin
				ctrl1 <= PWDATA_I[7:0];
			end
			if (done && PADDR_I == stm_pkg::ADDR_CTRL0) begin
				on <= PWDATA_I[stm_pkg::ON_BIT];
			end
			if (done && PADDR_I <= stm_pkg::ADDR_CTRL1) begin
				quiet <= 3'h0;
			end else if (quiet != 3'h7) begin
				quiet <= quiet + 3'h1;
			end
		end
	end
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// ==================================================
	// Bus handshake
	sequence s_wait;
		PSEL_I && PENABLE_I && !PREADY_O;
	endsequence
	sequence s_done;
		PSEL_I && PENABLE_I && PREADY_O;
	endsequence
	property p_one_wait;
		$rose(PSEL_I && PENABLE_I) |-> s_wait ##1 s_done;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("ready not after one wait state");
	property p_ready_once;
		PREADY_O |=> !PREADY_O;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
	property p_ready_access;
		PREADY_O |-> PSEL_I && PENABLE_I;
	endproperty
	a_ready_access: assert property (p_ready_access) else $error("ready outside access phase");
	property p_err_map;
		PREADY_O |-> PSLVERR_O == (PADDR_I > stm_pkg::ADDR_FLAGS || PADDR_I[1:0] != 2'b00);
	endproperty
	a_err_map: assert property (p_err_map) else $error("error response does not match map");
	property p_err_data;
		PREADY_O && PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0;
	endproperty
	a_err_data: assert property (p_err_data) else $error("refused read returns data");
	property p_narrow;
		PREADY_O && !PWRITE_I && PADDR_I >= stm_pkg::ADDR_COMPARE_A_VALUE_HI |-> PRDATA_O[31:2] == 30'h0;
	endproperty
	a_narrow: assert property (p_narrow) else $error("unused read bits not zero");
	// ==================================================
	// Output pin
	property p_oe_mode;
		quiet >= 3'h4 |-> PIN_OE_N_O == ctrl1[stm_pkg::MODE_LSB];
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("pin enable wrong for mode");
	property p_keep_pin;
		quiet >= 3'h4 && ctrl1[7:4] == 4'h0 |=> $stable(PIN_O);
	endproperty
	a_keep_pin: assert property (p_keep_pin) else $error("pin moved with no function");
	property p_force;
		on && quiet >= 3'h4 && ctrl1[7:5] == 3'b100 |-> PIN_O == !(^ctrl1[4:2]);
	endproperty
	a_force: assert property (p_force) else $error("forced level wrong");
endmodule : stm_timer_asserts
bind stm_timer stm_timer_asserts i_stm_timer_asserts (
	.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .EXT_CLK_I(EXT_CLK_I), .CAPTURE_I(CAPTURE_I),
	.PIN_O(PIN_O), .PIN_OE_N_O(PIN_OE_N_O)
);
`default_nettype wire

// ==== verif/stm_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module stm_pin_model (
	// Clock
	input  wire logic clk_i,
	// Output pin as seen by the load
	input  wire logic pin_i,
	// Trigger and capture sources
	output logic      ext_o,
	output logic      cap_o
);
	// ==================================================
	// Sources idle low
	initial begin
		ext_o = 1'b0;
		cap_o = 1'b0;
	end
	// One rising trigger edge on the external clock pin
	task automatic trigger();
		@(posedge clk_i);
		ext_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		ext_o <= 1'b0;
	endtask : trigger
	// Capture source rises after t_rise cycles, falls t_fall later
	task automatic cap_pulse(input int t_rise, input int t_fall);
		repeat (t_rise) @(posedge clk_i);
		cap_o <= 1'b1;
		repeat (t_fall) @(posedge clk_i);
		cap_o <= 1'b0;
	endtask : cap_pulse
	// Load counts the cycles the pin sits high
	task automatic measure(input int n, output int hi);
		hi = 0;
		repeat (n) begin
			@(posedge clk_i);
			hi += int'(pin_i === 1'b1);
		end
	endtask : measure
endmodule : stm_pin_model
`default_nettype wire

// ==== verif/stm_timer_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module stm_timer_tb_top;
	// ==================================================
	// Signals and bookkeeping
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_pin;
	logic        cap_pin;
	logic        pin;
	logic        pin_oe_n;
	logic [31:0] rd;
	logic        err;
	logic [9:0]  cv;
	int          hi;
	int          t;
	int          err_count = 0;
	int          samples_checked = 0;
	// PWM cases: control, P value, A value, window, expected high cycles
	logic [7:0]  pw_c1 [8] = '{8'ha8, 8'hac, 8'ha9, 8'haa, 8'ha8, 8'h88, 8'h98, 8'ha8};
	logic [2:0]  pw_p [8]  = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0};
	logic [9:0]  pw_a [8]  = '{10'd32, 10'd32, 10'd32, 10'd200, 10'd200, 10'd32, 10'd32, 10'd256};
	int          pw_n [8]  = '{256, 256, 256, 400, 256, 256, 256, 1024};
	int          pw_hi [8] = '{64, 192, 64, 256, 256, 0, 256, 256};
	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	stm_timer i_stm_timer (
		.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.EXT_CLK_I(ext_pin), .CAPTURE_I(cap_pin), .PIN_O(pin), .PIN_OE_N_O(pin_oe_n)
	);
	stm_pin_model i_stm_pin_model (.clk_i(clk), .pin_i(pin), .ext_o(ext_pin), .cap_o(cap_pin));
	// ==================================================
	// Bus and check tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One transfer: setup, access held until ready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16)
			chk("bus answer", 32'h1, 32'h0);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask : rdchk
	// Reprogram with the counter off, then start it or leave it off
	task automatic run(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a, input logic on);
		wr(stm_pkg::ADDR_CTRL0, {28'h1, 1'b0, p});
		wr(stm_pkg::ADDR_CTRL1, {24'h0, c1});
		wr(stm_pkg::ADDR_COMPARE_A_VALUE_LO, {24'h0, a[7:0]});
		wr(stm_pkg::ADDR_COMPARE_A_VALUE_HI, {30'h0, a[9:8]});
		wr(stm_pkg::ADDR_FLAGS, 32'h3);
		wr(stm_pkg::ADDR_CTRL0, {28'h1, on, p});
	endtask : run
	task automatic conclude();
		$display("Compares %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		conclude();
	end
	// ==================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			rdchk("reset value", 8'(4 * i), 32'h0);
		chk("oe after reset", 32'h0, 32'(pin_oe_n));
		wr(stm_pkg::ADDR_COMPARE_A_VALUE_HI, 32'hff);
		rdchk("compare a high", stm_pkg::ADDR_COMPARE_A_VALUE_HI, 32'h3);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, 32'(err));
		// Compare mode, clear on A, every pin function
		for (int f = 0; f < 4; f++) begin
			run({2'b00, 2'(f), f == 1, 3'b001}, 3'h1, 10'd200, 1'b1);
			repeat (4) @(posedge clk);
			chk("pin start", 32'(f == 1), 32'(pin));
			repeat (210) @(posedge clk);
			chk("pin on match", 32'(f >= 2), 32'(pin));
			rdchk("flags a clear", stm_pkg::ADDR_FLAGS, 32'h1);
		end
		// Clear on P in compare and timer mode
		for (int m = 0; m < 2; m++) begin
			run({m[0], m[0], 6'h20}, 3'h1, 10'd20, 1'b1);
			repeat (150) @(posedge clk);
			rdchk("flags p clear", stm_pkg::ADDR_FLAGS, 32'h3);
			apb(1'b0, stm_pkg::ADDR_COUNT, 32'h0);
			chk("count below p", 32'h1, 32'(rd < 32'd128));
			chk("oe by mode", 32'(m[0]), 32'(pin_oe_n));
		end
		// Zero compare A in timer mode: no A match, counter wraps
		run(8'hc1, 3'h0, 10'd0, 1'b1);
		repeat (1100) @(posedge clk);
		rdchk("flags overflow", stm_pkg::ADDR_FLAGS, 32'h0);
		wr(stm_pkg::ADDR_CTRL0, 32'h10);
		apb(1'b0, stm_pkg::ADDR_COUNT, 32'h0);
		chk("count wrapped", 32'h1, 32'(rd > 32'd0 && rd < 32'd200));
		repeat (20) @(posedge clk);
		rdchk("count held", stm_pkg::ADDR_COUNT, rd);
		// Quarter-rate internal clock: about one tick in four cycles
		wr(stm_pkg::ADDR_CTRL0, 32'h08);
		repeat (400) @(posedge clk);
		apb(1'b0, stm_pkg::ADDR_COUNT, 32'h0);
		chk("count at quarter rate", 32'h1, 32'(rd >= 32'd98 && rd <= 32'd104));
		// PWM table
		for (int i = 0; i < 8; i++) begin
			run(pw_c1[i], pw_p[i], pw_a[i], 1'b1);
			repeat (20) @(posedge clk);
			i_stm_pin_model.measure(pw_n[i], hi);
			chk("pwm high cycles", pw_hi[i], hi);
			if (i == 0)
				rdchk("pwm flags", stm_pkg::ADDR_FLAGS, 32'h3);
		end
		// Single pulse from the pin, then from software
		run(8'hb8, 3'h1, 10'd200, 1'b0);
		fork
			i_stm_pin_model.trigger();
			i_stm_pin_model.measure(300, hi);
		join
		// One cycle zeroes the counter as the on bit rises, then the A count runs
		chk("pulse width", 32'd201, hi);
		rdchk("pulse on cleared", stm_pkg::ADDR_CTRL0, 32'h11);
		rdchk("pulse flag", stm_pkg::ADDR_FLAGS, 32'h1);
		fork
			i_stm_pin_model.measure(60, hi);
			begin
				wr(stm_pkg::ADDR_CTRL0, 32'h18);
				wr(stm_pkg::ADDR_CTRL0, 32'h10);
			end
		join
		chk("software pulse", 32'h1, 32'(hi > 0 && hi < 50));
		// Capture on each edge code
		for (int f = 0; f < 4; f++) begin
			run({2'b01, 2'(f), 4'h0}, 3'h2, 10'd0, 1'b1);
			i_stm_pin_model.cap_pulse(100, 100);
			repeat (100) @(posedge clk);
			apb(1'b0, stm_pkg::ADDR_COMPARE_A_VALUE_LO, 32'h0);
			cv[7:0] = rd[7:0];
			apb(1'b0, stm_pkg::ADDR_COMPARE_A_VALUE_HI, 32'h0);
			cv[9:8] = rd[1:0];
			t = (f == 0) ? 100 : (f == 3) ? 0 : 200;
			chk("captured count", 32'h1, 32'(cv + 10'd4 >= t && cv <= t + 4));
			rdchk("capture flags", stm_pkg::ADDR_FLAGS, (f == 3) ? 32'h2 : 32'h3);
		end
		conclude();
	end
endmodule : stm_timer_tb_top
`default_nettype wire
